//--- shared/row_scan_consts.vh
/*
  Constants for the row-address scanner: reset state, state width,
  row count and counter-clock timing figures.
  Assumes inclusion by the design files under the bare name.
*/
`ifndef ROW_SCAN_CONSTS_VH
`define ROW_SCAN_CONSTS_VH

// ==========================================================
// Scan state
`define SCAN_W          4
`define SCAN_IDLE       4'h0
`define ROW_COUNT       13

// ==========================================================
// Timing
`define CLK_PERIOD_NS   10
`define CNT_CLK_MIN_NS  1000
`define CNT_CLK_MIN_CYC ((`CNT_CLK_MIN_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

//--- design/row_decoder.v
/*
  Scan-state to row decoder: one-hot row vector, 13 rows, or none.
  Assumes a 4-bit state; combinational only, the parent registers it.
*/
`include "row_scan_consts.vh"

module row_decoder (
  input  wire [3:0]  state,   // Scan state
  output reg  [12:0] rows     // One-hot row vector
);

  // ==========================================================
  // Decode
  always @* begin
    case (state) // R3
      4'h1:    rows = 13'h0001;
      4'h3:    rows = 13'h0002;
      4'h2:    rows = 13'h0004;
      4'h6:    rows = 13'h0008;
      4'h7:    rows = 13'h0010;
      4'h5:    rows = 13'h0020;
      4'h4:    rows = 13'h0040;
      4'hc:    rows = 13'h0080;
      4'hd:    rows = 13'h0100;
      4'hf:    rows = 13'h0200;
      4'he:    rows = 13'h0400;
      4'ha:    rows = 13'h0800;
      4'h8:    rows = 13'h1000;
      default: rows = 13'h0000;
    endcase
  end

endmodule

//--- design/head_row_address_scanner.v
/*
  Row-address scanner for a dual matrix head: a reflected 14-state
  scan counter or direct selector bits, decoded to 13 rows per head.
  The counter clock is sampled as a level and its rising edge becomes
  a one-cycle step pulse, so the counter never runs on a second clock.
  The counter keeps its count while the selector pins drive the state.
  Assumes all inputs synchronous to CLK; the controller keeps the
  control inputs stable around the channel enable edge and keeps the
  counter clock low for at least one CLK before each rise.
  Row outputs and the scan state are registered: every change shows
  one CLK after the inputs that cause it are sampled.
*/
// Notes on behaviour
// R1 - With the counter enabled, direction high and clear high, each counter clock steps the up sequence.
// R2 - With the counter enabled, direction low and clear high, each counter clock steps the down sequence.
// R3 - Each nonzero sequence state activates exactly one of 13 rows; 0000, 1001 and 1011 activate none.
// R4 - With the counter disabled, the selector inputs drive the state bits directly, bit n to bit n.
// R5 - Both heads use the same decoding and rows are active only while the channel enable is low.
// R6 - The controller holds its inputs stable around the enable edge and clocks via counter_clock_sel0.
// R7 - Clear low with the counter enabled returns the state to 0000 so all rows go inactive.
`include "row_scan_consts.vh"

module head_row_address_scanner (
  input  wire        CLK,                      // System clock, 100 MHz
  input  wire        RESET,                    // Synchronous reset, active high
  input  wire        INTERNAL_COUNTER_ENABLE,  // High: counter drives state
  input  wire        COUNT_DIRECTION_SEL2,     // Up when high / selector bit 2
  input  wire        COUNTER_CLEAR_SEL1,       // Clear when low / selector bit 1
  input  wire        COUNTER_CLOCK_SEL0,       // Counter clock / selector bit 0
  input  wire        SELECTOR_BIT3,            // Selector bit 3
  input  wire        CHANNEL_OUTPUT_ENABLE_N,  // Rows active while low
  input  wire        HEAD_SELECT,              // 0: head A, 1: head B
  output reg  [3:0]  SCAN_STATE,               // Effective scan state
  output reg  [12:0] ROWS_A,                   // Head A row outputs
  output reg  [12:0] ROWS_B                    // Head B row outputs
);

  // ==========================================================
  // Scan state codes in up-count order; neighbours differ in one bit,
  // so a step never moves more than one state line at a time
  localparam [3:0] ST_IDLE  = `SCAN_IDLE;
  localparam [3:0] ST_ROW1  = 4'h1;
  localparam [3:0] ST_ROW2  = 4'h3;
  localparam [3:0] ST_ROW3  = 4'h2;
  localparam [3:0] ST_ROW4  = 4'h6;
  localparam [3:0] ST_ROW5  = 4'h7;
  localparam [3:0] ST_ROW6  = 4'h5;
  localparam [3:0] ST_ROW7  = 4'h4;
  localparam [3:0] ST_ROW8  = 4'hc;
  localparam [3:0] ST_ROW9  = 4'hd;
  localparam [3:0] ST_ROW10 = 4'hf;
  localparam [3:0] ST_ROW11 = 4'he;
  localparam [3:0] ST_ROW12 = 4'ha;
  localparam [3:0] ST_ROW13 = 4'h8;
  // Codes off the walk: no row, and the counter falls back to idle from them
  localparam [3:0] ST_GAP9  = 4'h9;
  localparam [3:0] ST_GAPB  = 4'hb;

  // ==========================================================
  // Sequence stepping
  function [3:0] step_up;
    input [3:0] s;
    begin
      case (s)
        ST_IDLE:  step_up = ST_ROW1;
        ST_ROW1:  step_up = ST_ROW2;
        ST_ROW2:  step_up = ST_ROW3;
        ST_ROW3:  step_up = ST_ROW4;
        ST_ROW4:  step_up = ST_ROW5;
        ST_ROW5:  step_up = ST_ROW6;
        ST_ROW6:  step_up = ST_ROW7;
        ST_ROW7:  step_up = ST_ROW8;
        ST_ROW8:  step_up = ST_ROW9;
        ST_ROW9:  step_up = ST_ROW10;
        ST_ROW10: step_up = ST_ROW11;
        ST_ROW11: step_up = ST_ROW12;
        ST_ROW12: step_up = ST_ROW13;
        ST_ROW13: step_up = ST_IDLE;
        ST_GAP9:  step_up = ST_IDLE;
        ST_GAPB:  step_up = ST_IDLE;
      endcase
    end
  endfunction

  function [3:0] step_down;
    input [3:0] s;
    begin
      case (s)
        ST_IDLE:  step_down = ST_ROW13;
        ST_ROW13: step_down = ST_ROW12;
        ST_ROW12: step_down = ST_ROW11;
        ST_ROW11: step_down = ST_ROW10;
        ST_ROW10: step_down = ST_ROW9;
        ST_ROW9:  step_down = ST_ROW8;
        ST_ROW8:  step_down = ST_ROW7;
        ST_ROW7:  step_down = ST_ROW6;
        ST_ROW6:  step_down = ST_ROW5;
        ST_ROW5:  step_down = ST_ROW4;
        ST_ROW4:  step_down = ST_ROW3;
        ST_ROW3:  step_down = ST_ROW2;
        ST_ROW2:  step_down = ST_ROW1;
        ST_ROW1:  step_down = ST_IDLE;
        ST_GAP9:  step_down = ST_IDLE;
        ST_GAPB:  step_down = ST_IDLE;
      endcase
    end
  endfunction

  // ==========================================================
  // Counter
  localparam [1:0] ACT_HOLD  = 2'b00;
  localparam [1:0] ACT_CLEAR = 2'b01;
  localparam [1:0] ACT_UP    = 2'b10;
  localparam [1:0] ACT_DOWN  = 2'b11;

  reg  [3:0]  count_r;
  reg  [3:0]  count_nxt;
  reg  [1:0]  act;
  reg         clk_in_r;
  wire        cnt_edge;
  wire [3:0]  sel_bits;
  wire [3:0]  state_sel;
  wire [12:0] rows_dec;
  wire        head_a_on;
  wire        head_b_on;

  // Counter clock is an ordinary input; its rising edge is a one-cycle step enable
  assign cnt_edge = COUNTER_CLOCK_SEL0 & ~clk_in_r; // R6

  // Clear wins over a step in the same CLK; the count holds while disabled,
  // so going back to counter mode resumes where the scan left off
  always @* begin
    act = ACT_HOLD;
    if (INTERNAL_COUNTER_ENABLE) begin
      if (!COUNTER_CLEAR_SEL1) begin
        act = ACT_CLEAR; // R7
      end else if (cnt_edge) begin
        if (COUNT_DIRECTION_SEL2) begin
          act = ACT_UP; // R1
        end else begin
          act = ACT_DOWN; // R2
        end
      end
    end
  end

  always @* begin
    case (act)
      ACT_CLEAR: count_nxt = ST_IDLE; // R7
      ACT_UP:    count_nxt = step_up(count_r); // R1
      ACT_DOWN:  count_nxt = step_down(count_r); // R2
      default:   count_nxt = count_r;
    endcase
  end

  // The edge register follows the pin in reset and in selector mode too, so a
  // pin already high at release or at a mode change gives no false step
  always @(posedge CLK) begin
    clk_in_r <= COUNTER_CLOCK_SEL0;
  end

  always @(posedge CLK) begin
    if (RESET) begin
      count_r <= ST_IDLE;
    end else begin
      count_r <= count_nxt;
    end
  end

  // ==========================================================
  // Selector mode
  // The selector pins share the counter controls; the state follows them directly
  assign sel_bits  = {SELECTOR_BIT3, COUNT_DIRECTION_SEL2, COUNTER_CLEAR_SEL1, COUNTER_CLOCK_SEL0}; // R4
  assign state_sel = INTERNAL_COUNTER_ENABLE ? count_nxt : sel_bits; // R4

  row_decoder u_dec (
    .state (state_sel),
    .rows  (rows_dec)
  );

  // ==========================================================
  // Outputs
  // One decoder serves both heads; only the selected head is driven, and
  // since rows change only on CLK a head swap never lights both heads
  assign head_a_on = ~CHANNEL_OUTPUT_ENABLE_N & ~HEAD_SELECT; // R5
  assign head_b_on = ~CHANNEL_OUTPUT_ENABLE_N &  HEAD_SELECT; // R5

  function [12:0] gate_rows;
    input        on;
    input [12:0] in_rows;
    begin
      if (on) begin
        gate_rows = in_rows;
      end else begin
        gate_rows = 13'h0000;
      end
    end
  endfunction

  always @(posedge CLK) begin
    if (RESET) begin
      SCAN_STATE <= ST_IDLE;
    end else begin
      SCAN_STATE <= state_sel;
    end
  end

  always @(posedge CLK) begin
    if (RESET) begin
      ROWS_A <= 13'h0000;
    end else begin
      ROWS_A <= gate_rows(head_a_on, rows_dec); // R5
    end
  end

  always @(posedge CLK) begin
    if (RESET) begin
      ROWS_B <= 13'h0000;
    end else begin
      ROWS_B <= gate_rows(head_b_on, rows_dec); // R5
    end
  end

endmodule

//--- tb/scan_ctl_model.sv
/* Controller model driving the scan pins.
   Assumes the bench calls set and pulse. */
module scan_ctl_model (
  input  wire logic       CLK,  // Clock
  output logic      [6:0] pins  // En, dir, clear, clock, bit3, enable_n, head
);
  timeunit 1ns;
  timeprecision 100ps;
  initial pins = 7'h00;
  task automatic set(input logic [6:0] v);
    @(negedge CLK) pins = v;
  endtask
  // Kept just under the 1 MHz ceiling, 1010 ns per pulse, so timing margins are never borrowed
  task automatic pulse();
    set(pins | 7'h08);
    repeat (50) @(negedge CLK);
    set(pins & 7'h77);
    repeat (49) @(negedge CLK);
  endtask
endmodule

//--- tb/scan_monitor.sv
/* Port assertions. Assumes binding onto the scanner top. */
module scan_monitor (
  input wire logic        CLK,                      // Clock
  input wire logic        RESET,                    // Reset
  input wire logic        INTERNAL_COUNTER_ENABLE,  // Counter mode
  input wire logic        COUNT_DIRECTION_SEL2,     // Direction / sel 2
  input wire logic        COUNTER_CLEAR_SEL1,       // Clear / sel 1
  input wire logic        COUNTER_CLOCK_SEL0,       // Count clock / sel 0
  input wire logic        SELECTOR_BIT3,            // Sel 3
  input wire logic        CHANNEL_OUTPUT_ENABLE_N,  // Row enable, low
  input wire logic        HEAD_SELECT,              // Head select
  input wire logic [3:0]  SCAN_STATE,               // State out
  input wire logic [12:0] ROWS_A,                   // Head A rows
  input wire logic [12:0] ROWS_B                    // Head B rows
);
  timeunit 1ns;
  timeprecision 100ps;
  localparam logic [55:0] SEQ = 56'h01326754cdfea8;
  function automatic int pos(input logic [3:0] s);
    for (int i = 0; i < 14; i++) if (SEQ[55-4*i -: 4] == s) return i;
    return 0;
  endfunction
  default clocking @(posedge CLK); endclocking
  default disable iff (RESET);
  wire logic [3:0] sel = {SELECTOR_BIT3, COUNT_DIRECTION_SEL2, COUNTER_CLEAR_SEL1, COUNTER_CLOCK_SEL0};
  wire logic stp = INTERNAL_COUNTER_ENABLE && COUNTER_CLEAR_SEL1;
  AST_STEP: assert property (stp && $past(INTERNAL_COUNTER_ENABLE) && $rose(COUNTER_CLOCK_SEL0)
    |=> SCAN_STATE == SEQ[55-4*((pos($past(SCAN_STATE)) + ($past(COUNT_DIRECTION_SEL2) ? 1 : 13)) % 14) -: 4])
    else $error("step");
  AST_CLR: assert property (INTERNAL_COUNTER_ENABLE && !COUNTER_CLEAR_SEL1 |=> SCAN_STATE == 4'h0)
    else $error("clear");
  AST_SEL: assert property (!INTERNAL_COUNTER_ENABLE |=> SCAN_STATE == $past(sel)) else $error("sel");
  AST_OFF: assert property (CHANNEL_OUTPUT_ENABLE_N |=> (ROWS_A | ROWS_B) == 13'h0) else $error("off");
  AST_ONE: assert property ($onehot0({ROWS_A, ROWS_B})) else $error("one");
  AST_DEC: assert property (!$past(CHANNEL_OUTPUT_ENABLE_N) |-> ($past(HEAD_SELECT) ? ROWS_B : ROWS_A) ==
    (pos(SCAN_STATE) == 0 ? 13'h0 : 13'h1 << (pos(SCAN_STATE) - 1))) else $error("dec");
endmodule
bind head_row_address_scanner scan_monitor i_mon (.*);

//--- tb/head_row_address_scanner_tb.sv
/* Bench for the scanner. Assumes the controller model drives all pins but CLK and RESET. */
module head_row_address_scanner_tb;
  timeunit 1ns;
  timeprecision 100ps;
  localparam logic [55:0] SEQ = 56'h01326754cdfea8;
  logic clk = 0, reset = 1;
  logic [6:0] p;
  logic [3:0] st, e;
  logic [12:0] ra, rb, r;
  int num_errors = 0, checks_done = 0, k;
  scan_ctl_model i_ctl (.CLK(clk), .pins(p));
  head_row_address_scanner i_dut (.CLK(clk), .RESET(reset), .INTERNAL_COUNTER_ENABLE(p[6]),
    .COUNT_DIRECTION_SEL2(p[5]), .COUNTER_CLEAR_SEL1(p[4]), .COUNTER_CLOCK_SEL0(p[3]), .SELECTOR_BIT3(p[2]),
    .CHANNEL_OUTPUT_ENABLE_N(p[1]), .HEAD_SELECT(p[0]), .SCAN_STATE(st), .ROWS_A(ra), .ROWS_B(rb));
  initial forever #5 clk = ~clk;
  task automatic chk(input string n, input logic [16:0] x, input logic [16:0] g);
    checks_done++;
    if (g !== x) begin
      num_errors++;
      $display("MISMATCH %s exp %h got %h", n, x, g);
    end
  endtask
  task automatic summarize();
    $display("checks %0d errors %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  initial begin
    repeat (12) @(negedge clk);
    reset = 0;
    for (int d = 0; d < 2; d++) begin
      i_ctl.set(d ? 7'h51 : 7'h70);
      for (int i = 1; i < 15; i++) begin
        i_ctl.pulse();
        k = (d ? 14 - i : i) % 14;
        r = k ? 13'h1 << (k - 1) : 13'h0;
        chk("scan", {SEQ[55-4*k -: 4], r}, {st, d ? rb : ra});
      end
      $display("test direction %0d done", d);
    end
    i_ctl.pulse();
    chk("head b", {4'h8, 13'h1000}, {st, rb});
    reset = 1;
    repeat (2) @(negedge clk);
    chk("reset b", 17'h0, {st, rb});
    chk("reset a", 17'h0, {4'h0, ra});
    reset = 0;
    $display("test reset done");
    i_ctl.pulse();
    i_ctl.set(7'h41);
    i_ctl.pulse();
    chk("clear", 17'h0, {st, rb});
    for (k = 0; k < 16; k++) begin
      e = k < 14 ? SEQ[55-4*k -: 4] : {2'b10, k[0], 1'b1};
      r = (k > 0 && k < 14) ? 13'h1 << (k - 1) : 13'h0;
      i_ctl.set({1'b0, e[2:0], e[3], 2'b00});
      @(negedge clk);
      chk("select", {e, r}, {st, ra});
    end
    i_ctl.set(7'h2a);
    @(negedge clk);
    chk("off", {4'h5, 13'h0}, {st, ra});
    $display("test modes done");
    summarize();
  end
endmodule
